// *** verilog/cdpm_params.svh ***
`ifndef CDPM_PARAMS_SVH
`define CDPM_PARAMS_SVH

// Divider select width; ratio is 2**sel
`define CDPM_SEL_W        2
// Divider counter width, enough for ratio 8
`define CDPM_CNT_W        3
// Largest select codes per divider
`define CDPM_REF_SEL_MAX  2'h3
`define CDPM_AHB_SEL_MAX  2'h2
`define CDPM_APB_SEL_MAX  2'h3
`define CDPM_EMI_SEL_MAX  2'h1
`define CDPM_FLASH_SEL_MAX 2'h1
// Reset value of every divider select (divide by 1)
`define CDPM_SEL_RST      2'h0
// Number of maskable peripheral clocks
`define CDPM_NPERIPH      8
// Peripheral slot numbers that may run from an external pin
`define CDPM_SLOT_USB     0
`define CDPM_SLOT_TIM01   1
`define CDPM_SLOT_TIM23   2

`endif

// *** verilog/cdpm_pkg.sv ***
package cdpm_pkg;

   // Power mode, one-hot
   typedef enum logic [2:0] {
      CDPM_RUN   = 3'b001,
      CDPM_IDLE  = 3'b010,
      CDPM_SLEEP = 3'b100
   } cdpm_mode_t;

   // Reset sources reported by the reset unit, level while active
   typedef struct packed {
      logic extPin;   // External reset pin
      logic wdog;     // Watchdog
      logic lowVolt;  // Low-voltage detect
      logic powerUp;  // Power-up
      logic jtagCmd;  // Debug command
   } cdpm_rstsrc_t;

   // Divider ratio selects, ratio is 2**sel
   typedef struct packed {
      logic [1:0] refSel;
      logic [1:0] ahbSel;
      logic [1:0] apbSel;
      logic [1:0] emiSel;
      logic [1:0] flashSel;
   } cdpm_divcfg_t;

   // External clock choices for peripherals with a dedicated pin
   typedef struct packed {
      logic usbSel;
      logic tim01Sel;
      logic tim23Sel;
   } cdpm_extsel_t;

endpackage

// *** verilog/cdpm_div.sv ***
`timescale 1ns/1ns
`include "cdpm_params.svh"

// Tick divider: passes every 2**sel-th input tick, whole periods only
module cdpm_div (
   input  wire logic                   clk,
   input  wire logic                   rstN,
   input  wire logic                   tickIn,
   input  wire logic [`CDPM_SEL_W-1:0] sel,
   input  wire logic [`CDPM_SEL_W-1:0] selMax,
   input  wire logic                   gateOpen,
   output logic                        tickOut
);
   logic [`CDPM_CNT_W-1:0] cnt_r;     // Input ticks in current period
   logic [`CDPM_SEL_W-1:0] selAct_r;  // Ratio in force this period
   logic                   gate_r;    // Gate in force this period
   logic [`CDPM_CNT_W-1:0] last;      // Terminal count
   logic                   term;      // Period ends on this tick
   logic [`CDPM_SEL_W-1:0] selSafe;   // Request clipped to legal range

   assign last    = `CDPM_CNT_W'((1 << selAct_r) - 1);
   assign term    = tickIn && (cnt_r == last);
   assign selSafe = (sel > selMax) ? selMax : sel;
   // Output only on a period boundary, so no pulse is ever cut short
   assign tickOut = term && gate_r;

   // Period counter
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cnt_r <= '0;
      end else if (term) begin
         cnt_r <= '0;
      end else if (tickIn) begin
         cnt_r <= cnt_r + `CDPM_CNT_W'(1);
      end
   end

   // Ratio and gate change at a boundary, or on any cycle while the gate is shut
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         selAct_r <= `CDPM_SEL_RST;
         gate_r   <= 1'b1;
      end else if (term || !gate_r) begin
         selAct_r <= selSafe;
         gate_r   <= gateOpen;
      end
   end
endmodule

// *** verilog/cdpm_clock_power.sv ***
`timescale 1ns/1ns
`include "cdpm_params.svh"

// How it works
// - Main clock divided into reference clock
// - AHB clock is reference over 1,2,4
// - APB clock is reference over 1,2,4,8
// - Some AHB peripherals time transfers on APB
// - USB, timer pairs may use external pins
// - Idle bit stops core, flash clocks immediately
// - Idle keeps peripheral mask from before entry
// - Any reset source ends Idle
// - Any interrupt ends Idle
// - Wake-up unit input ends Idle
// - Sleep stops all but RTC, oscillator off
// - Sleep exit evaluated on RTC clock ticks
// - Sleep exits exclude watchdog reset
//
// Every derived clock is a one-cycle enable on clk_sys marking the
// rising edge of that clock; whole enables cannot glitch.
module cdpm_clock_power (
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   input  wire cdpm_pkg::cdpm_divcfg_t   divCfg,
   input  wire cdpm_pkg::cdpm_extsel_t   extSel,
   input  wire logic [`CDPM_NPERIPH-1:0] periphMask,
   input  wire logic                     idleSet,
   input  wire logic                     sleepSet,
   input  wire cdpm_pkg::cdpm_rstsrc_t   rstSrc,
   input  wire logic                     irqAny,
   input  wire logic                     rtcAlarm,
   input  wire logic                     wakeIn,
   input  wire logic                     rtcClkIn,
   input  wire logic                     usbExtClk,
   input  wire logic                     tim01ExtClk,
   input  wire logic                     tim23ExtClk,
   output logic                          refClkEn,
   output logic                          coreClkEn,
   output logic                          ahbClkEn,
   output logic                          apbClkEn,
   output logic                          ahbPeriphXferEn,
   output logic                          emiClkEn,
   output logic                          flashClkEn,
   output logic [`CDPM_NPERIPH-1:0]      periphClkEn,
   output logic                          mainOscEn,
   output logic                          cpuHalted,
   output cdpm_pkg::cdpm_mode_t          modeOut
);

   logic                     rstSync1_r;   // Reset release stage 1
   logic                     rstSync2_r;   // Released reset for the block
   cdpm_pkg::cdpm_mode_t     mode_r;       // Power mode
   cdpm_pkg::cdpm_mode_t     mode_nxt;     // Next power mode
   logic [`CDPM_NPERIPH-1:0] idleMask_r;   // Mask frozen at idle entry
   logic [`CDPM_NPERIPH-1:0] maskEff;      // Mask currently in force
   logic                     rtcPrev_r;    // RTC clock last cycle
   logic                     rtcTick;      // RTC rising edge
   logic [2:0]               extPrev_r;    // External pins last cycle
   logic [2:0]               extTick;      // External pin rising edges
   logic                     coreRun;      // Core and flash may clock
   logic                     oscRun;       // Main oscillator running
   logic                     refTick;      // Reference clock edge
   logic                     ahbTick;      // AHB clock edge
   logic                     apbTick;      // APB clock edge
   logic                     emiTick;      // External memory clock edge
   logic                     flashTick;    // Flash interface clock edge
   logic                     anyReset;     // Any reset source
   logic                     sleepReset;   // Resets that may end sleep
   logic [`CDPM_NPERIPH-1:0] periphTick;   // Peripheral edges, pre-flop

   // Reset released through two flops, asserted at once
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstSync1_r <= 1'b0;
         rstSync2_r <= 1'b0;
      end else begin
         rstSync1_r <= 1'b1;
         rstSync2_r <= rstSync1_r;
      end
   end

   // Rising edge of a pin sampled on clk_sys
   function automatic logic riseOf(input logic now, input logic prev);
      riseOf = now && !prev;
   endfunction

   // Edge history of the RTC clock and external clock pins
   always_ff @(posedge clk_sys or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         rtcPrev_r <= 1'b0;
         extPrev_r <= 3'h0;
      end else begin
         rtcPrev_r <= rtcClkIn;
         extPrev_r <= {tim23ExtClk, tim01ExtClk, usbExtClk};
      end
   end

   assign rtcTick = riseOf(rtcClkIn, rtcPrev_r);
   assign extTick[0] = riseOf(usbExtClk, extPrev_r[0]);
   assign extTick[1] = riseOf(tim01ExtClk, extPrev_r[1]);
   assign extTick[2] = riseOf(tim23ExtClk, extPrev_r[2]);

   // Reset source groups; watchdog cannot end sleep
   assign anyReset   = |rstSrc;
   assign sleepReset = rstSrc.extPin || rstSrc.lowVolt || rstSrc.powerUp
                       || rstSrc.jtagCmd;

   // Mode transitions
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         cdpm_pkg::CDPM_RUN: begin
            // A pending reset keeps the device running
            if (!anyReset && sleepSet) begin
               mode_nxt = cdpm_pkg::CDPM_SLEEP;
            end else if (!anyReset && idleSet) begin
               mode_nxt = cdpm_pkg::CDPM_IDLE;
            end
         end
         cdpm_pkg::CDPM_IDLE: begin
            if (anyReset || irqAny || wakeIn) begin
               mode_nxt = cdpm_pkg::CDPM_RUN;
            end
         end
         cdpm_pkg::CDPM_SLEEP: begin
            // Exit logic only moves on an RTC clock edge
            if (rtcTick && (sleepReset || rtcAlarm || wakeIn)) begin
               mode_nxt = cdpm_pkg::CDPM_RUN;
            end
         end
         default: begin
            mode_nxt = cdpm_pkg::CDPM_RUN;
         end
      endcase
   end

   // Mode register
   always_ff @(posedge clk_sys or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         mode_r <= cdpm_pkg::CDPM_RUN;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Peripheral mask frozen on the way into idle
   always_ff @(posedge clk_sys or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         idleMask_r <= '0;
      end else if (mode_r == cdpm_pkg::CDPM_RUN) begin
         idleMask_r <= periphMask;
      end
   end

   // Idle or sleep request gates the core in the same cycle
   assign coreRun = (mode_r == cdpm_pkg::CDPM_RUN) && !idleSet && !sleepSet;
   // Everything off the main oscillator stops in sleep
   assign oscRun  = (mode_r != cdpm_pkg::CDPM_SLEEP);
   assign maskEff = (mode_r == cdpm_pkg::CDPM_IDLE) ? idleMask_r : periphMask;

   // Reference divider from the main clock
   cdpm_div uRef (
      .clk      (clk_sys),
      .rstN     (rstSync2_r),
      .tickIn   (1'b1),
      .sel      (divCfg.refSel),
      .selMax   (`CDPM_REF_SEL_MAX),
      .gateOpen (oscRun),
      .tickOut  (refTick)
   );

   // Bus and memory dividers all fed by the reference clock
   cdpm_div uAhb (
      .clk      (clk_sys),
      .rstN     (rstSync2_r),
      .tickIn   (refTick),
      .sel      (divCfg.ahbSel),
      .selMax   (`CDPM_AHB_SEL_MAX),
      .gateOpen (oscRun),
      .tickOut  (ahbTick)
   );

   cdpm_div uApb (
      .clk      (clk_sys),
      .rstN     (rstSync2_r),
      .tickIn   (refTick),
      .sel      (divCfg.apbSel),
      .selMax   (`CDPM_APB_SEL_MAX),
      .gateOpen (oscRun),
      .tickOut  (apbTick)
   );

   cdpm_div uEmi (
      .clk      (clk_sys),
      .rstN     (rstSync2_r),
      .tickIn   (refTick),
      .sel      (divCfg.emiSel),
      .selMax   (`CDPM_EMI_SEL_MAX),
      .gateOpen (oscRun),
      .tickOut  (emiTick)
   );

   // Flash clock is stopped with the core
   cdpm_div uFlash (
      .clk      (clk_sys),
      .rstN     (rstSync2_r),
      .tickIn   (refTick),
      .sel      (divCfg.flashSel),
      .selMax   (`CDPM_FLASH_SEL_MAX),
      .gateOpen (coreRun),
      .tickOut  (flashTick)
   );

   // Peripheral clocks: APB timing, or a dedicated pin where allowed
   generate
      for (genvar i = 0; i < `CDPM_NPERIPH; i++) begin : gPeriph
         logic srcTick; // Chosen source edge
         if (i == `CDPM_SLOT_USB) begin : gUsb
            assign srcTick = extSel.usbSel ? extTick[0] : apbTick;
         end else if (i == `CDPM_SLOT_TIM01) begin : gT01
            assign srcTick = extSel.tim01Sel ? extTick[1] : apbTick;
         end else if (i == `CDPM_SLOT_TIM23) begin : gT23
            assign srcTick = extSel.tim23Sel ? extTick[2] : apbTick;
         end else begin : gApb
            assign srcTick = apbTick;
         end
         // Pin clocks also stop in sleep, as the whole chip is quiescent
         assign periphTick[i] = srcTick && maskEff[i] && oscRun;
      end
   endgenerate

   // Enable outputs from flops; the core enable is the gated reference
   always_ff @(posedge clk_sys or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         refClkEn        <= 1'b0;
         coreClkEn       <= 1'b0;
         ahbClkEn        <= 1'b0;
         apbClkEn        <= 1'b0;
         ahbPeriphXferEn <= 1'b0;
         emiClkEn        <= 1'b0;
         flashClkEn      <= 1'b0;
         periphClkEn     <= '0;
      end else begin
         refClkEn        <= refTick;
         coreClkEn       <= refTick && coreRun;
         ahbClkEn        <= ahbTick;
         apbClkEn        <= apbTick;
         ahbPeriphXferEn <= apbTick;
         emiClkEn        <= emiTick;
         // Flash edge dropped whole as soon as the core stops
         flashClkEn      <= flashTick && coreRun;
         periphClkEn     <= periphTick;
      end
   end

   // Status outputs
   always_ff @(posedge clk_sys or negedge rstSync2_r) begin
      if (!rstSync2_r) begin
         mainOscEn <= 1'b1;
         cpuHalted <= 1'b0;
         modeOut   <= cdpm_pkg::CDPM_RUN;
      end else begin
         mainOscEn <= (mode_nxt != cdpm_pkg::CDPM_SLEEP);
         cpuHalted <= (mode_nxt != cdpm_pkg::CDPM_RUN);
         modeOut   <= mode_nxt;
      end
   end

endmodule

// *** test/cdpm_clock_power_props.sv ***
`timescale 1ns/1ns

// Port-level checks on the clock and power-mode block
module cdpm_clock_power_props (
   input wire logic                   clk_sys,
   input wire logic                   nrst,
   input wire logic [7:0]             periphMask,
   input wire logic                   idleSet,
   input wire logic                   sleepSet,
   input wire cdpm_pkg::cdpm_rstsrc_t rstSrc,
   input wire logic                   irqAny,
   input wire logic                   rtcAlarm,
   input wire logic                   wakeIn,
   input wire logic                   rtcClkIn,
   input wire logic                   refClkEn,
   input wire logic                   coreClkEn,
   input wire logic                   ahbClkEn,
   input wire logic                   apbClkEn,
   input wire logic                   ahbPeriphXferEn,
   input wire logic                   flashClkEn,
   input wire logic [7:0]             periphClkEn,
   input wire logic                   mainOscEn,
   input wire logic                   cpuHalted,
   input wire cdpm_pkg::cdpm_mode_t   modeOut
);
   logic [1:0] up_r;   // Edges since nrst rose
   logic [7:0] frz_r;  // Mask as it stood at idle entry
   logic       live;   // Internal reset has lifted
   logic       run;
   logic       idl;
   logic       slp;
   logic       wsrc;   // Sources allowed to end sleep
   assign live = up_r == 2'h3;
   assign run  = modeOut == cdpm_pkg::CDPM_RUN;
   assign idl  = modeOut == cdpm_pkg::CDPM_IDLE;
   assign slp  = modeOut == cdpm_pkg::CDPM_SLEEP;
   assign wsrc = rstSrc.extPin | rstSrc.lowVolt | rstSrc.powerUp | rstSrc.jtagCmd
               | rtcAlarm | wakeIn;

   // Skip the two resynchronising flops, inputs are not legal there
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         up_r <= 2'h0;
      else if (!live)
         up_r <= up_r + 2'h1;
   end

   // Track the mask while running, hold it once idle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         frz_r <= 8'h00;
      else if (run)
         frz_r <= periphMask;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence sGoIdle;
      live && run && idleSet && !sleepSet && !(|rstSrc);
   endsequence
   sequence sIdleWake;
      idl && (irqAny || wakeIn || (|rstSrc));
   endsequence
   sequence sRtcRise;
      rtcClkIn && !$past(rtcClkIn);
   endsequence

   a_core_in_ref: assert property (coreClkEn |-> refClkEn)
      else $error("core pulse without reference pulse");
   a_ahb_in_ref: assert property (ahbClkEn |-> refClkEn)
      else $error("bus pulse off the reference grid");
   a_apb_in_ref: assert property (apbClkEn |-> refClkEn)
      else $error("peripheral bus pulse off the reference grid");
   a_xfer_on_apb: assert property (ahbPeriphXferEn == apbClkEn)
      else $error("transfer timing differs from peripheral bus clock");
   a_idle_entry: assert property (sGoIdle |=> idl && cpuHalted && !coreClkEn)
      else $error("idle request not taken");
   a_idle_gated: assert property (idl |-> !coreClkEn && !flashClkEn)
      else $error("core or flash clock running in idle");
   a_idle_mask: assert property (idl |-> (periphClkEn & ~frz_r) == 8'h00)
      else $error("peripheral clock outside entry mask in idle");
   a_idle_wake: assert property (sIdleWake |=> run)
      else $error("idle not left on wake source");
   a_sleep_quiet: assert property (slp |-> !mainOscEn && cpuHalted && !coreClkEn)
      else $error("oscillator or core active in sleep");
   a_sleep_hold: assert property (slp && !(rtcClkIn && !$past(rtcClkIn) && wsrc) |=> slp)
      else $error("sleep left without a valid source");
   a_sleep_exit: assert property (slp && wsrc ##0 sRtcRise |=> run && mainOscEn)
      else $error("sleep not left on rtc edge with source");
endmodule

bind cdpm_clock_power cdpm_clock_power_props i_cdpm_clock_power_props (
   .clk_sys, .nrst, .periphMask, .idleSet, .sleepSet, .rstSrc, .irqAny, .rtcAlarm,
   .wakeIn, .rtcClkIn, .refClkEn, .coreClkEn, .ahbClkEn, .apbClkEn, .ahbPeriphXferEn,
   .flashClkEn, .periphClkEn, .mainOscEn, .cpuHalted, .modeOut
);

// *** test/tb_cdpm_clock_power.sv ***
`timescale 1ns/1ns

module tb_cdpm_clock_power;
   logic                   clk_sys = 1'h0;  // 100 MHz
   logic                   nrst = 1'h0;
   cdpm_pkg::cdpm_divcfg_t divCfg = 10'h060;
   cdpm_pkg::cdpm_extsel_t extSel = 3'h0;
   cdpm_pkg::cdpm_rstsrc_t rstSrc = 5'h00;
   logic [7:0]             periphMask = 8'h00;
   logic                   idleSet = 1'h0, sleepSet = 1'h0, irqAny = 1'h0;
   logic                   rtcAlarm = 1'h0, wakeIn = 1'h0, rtcClkIn = 1'h0;
   logic [1:0]             ph = 2'h0;  // Pin clock phase, quarter rate
   logic                   refClkEn, coreClkEn, ahbClkEn, apbClkEn, ahbPeriphXferEn;
   logic                   emiClkEn, flashClkEn, mainOscEn, cpuHalted;
   logic [7:0]             periphClkEn;
   cdpm_pkg::cdpm_mode_t   modeOut;
   logic [7:0]             c [9];      // Pulse counts per output
   int                     mismatches = 0, comparisons = 0;

   always #5 clk_sys = ~clk_sys;
   // External pins well below clk_sys/2
   always @(negedge clk_sys) ph <= ph + 2'h1;

   cdpm_clock_power i_cdpm_clock_power (.clk_sys, .nrst, .divCfg, .extSel, .periphMask,
      .idleSet, .sleepSet, .rstSrc, .irqAny, .rtcAlarm, .wakeIn, .rtcClkIn,
      .usbExtClk(ph[1]), .tim01ExtClk(ph[1]), .tim23ExtClk(ph[1]), .refClkEn, .coreClkEn,
      .ahbClkEn, .apbClkEn, .ahbPeriphXferEn, .emiClkEn, .flashClkEn, .periphClkEn,
      .mainOscEn, .cpuHalted, .modeOut);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Whole periods only, so window counts are exact
   function automatic logic [7:0] e(input int sh);
      return 8'(64 >> sh);
   endfunction

   task automatic count(input int n);
      logic [8:0] v;
      for (int k = 0; k < 9; k++) c[k] = 8'h00;
      repeat (n) begin
         @(negedge clk_sys);
         v = {refClkEn, coreClkEn, ahbClkEn, apbClkEn, emiClkEn, flashClkEn, periphClkEn[2:0]};
         for (int k = 0; k < 9; k++) c[k] = c[k] + {7'h00, v[k]};
      end
   endtask

   // Every ratio code, clipped ones included
   task automatic t_ratio();
      int h;  // AHB code, bus kept at or under 96 MHz
      int a;  // APB code, bus kept at or under 48 MHz
      for (int r = 0; r < 4; r++) begin
         for (int s = 0; s < 4; s++) begin
            h = (r == 0 && s == 0) ? 1 : s;
            a = (r + s < 2) ? 2 - r : s;
            divCfg = {2'(r), 2'(h), 2'(a), 2'(s), 2'(s)};
            cyc(80);
            count(64);
            chk(c[8], e(r));
            chk(c[7], e(r));
            chk(c[6], e(r + (h > 2 ? 2 : h)));
            chk(c[5], e(r + a));
            chk(c[4], e(r + (s > 0 ? 1 : 0)));
            chk(c[3], e(r + (s > 0 ? 1 : 0)));
         end
      end
      divCfg = 10'h060;
      $display("t_ratio done");
   endtask

   // Idle entry, frozen mask, every wake source
   task automatic t_idle();
      extSel = 3'h7;
      periphMask = 8'h05;
      cyc(8);
      idleSet = 1'h1;
      cyc(1);
      idleSet = 1'h0;
      periphMask = 8'hff;
      chk({5'h00, modeOut}, 8'h02);
      chk({7'h00, cpuHalted}, 8'h01);
      count(32);
      chk(c[7], 8'h00);
      chk(c[3], 8'h00);
      chk(c[0], 8'h08);
      chk(c[1], 8'h00);
      chk(c[2], 8'h08);
      for (int k = 0; k < 7; k++) begin
         if (k > 0) begin
            idleSet = 1'h1;
            cyc(1);
            idleSet = 1'h0;
         end
         {irqAny, wakeIn, rstSrc} = 7'(1 << k);
         cyc(1);
         {irqAny, wakeIn, rstSrc} = 7'h00;
         chk({5'h00, modeOut}, 8'h01);
      end
      count(32);
      chk(c[1], 8'h08);
      $display("t_idle done");
   endtask

   task automatic wk(input logic [5:0] v);
      {rstSrc.extPin, rstSrc.lowVolt, rstSrc.powerUp, rstSrc.jtagCmd, rtcAlarm, wakeIn} = v;
   endtask

   // Sleep holds against wrong sources, leaves on rtc edge
   task automatic t_sleep();
      // Both requests at once: sleep wins
      {sleepSet, idleSet} = 2'h3;
      cyc(1);
      {sleepSet, idleSet} = 2'h0;
      irqAny = 1'h1;
      rstSrc.wdog = 1'h1;
      chk({5'h00, modeOut}, 8'h04);
      chk({7'h00, mainOscEn}, 8'h00);
      repeat (4) begin
         rtcClkIn = 1'h1;
         cyc(2);
         rtcClkIn = 1'h0;
         cyc(2);
      end
      chk({5'h00, modeOut}, 8'h04);
      irqAny = 1'h0;
      rstSrc.wdog = 1'h0;
      wakeIn = 1'h1;
      count(32);
      chk({5'h00, modeOut}, 8'h04);
      chk(c[8], 8'h00);
      for (int k = 0; k < 6; k++) begin
         wk(6'(1 << k));
         rtcClkIn = 1'h1;
         cyc(1);
         wk(6'h00);
         rtcClkIn = 1'h0;
         chk({5'h00, modeOut}, 8'h01);
         chk({7'h00, mainOscEn}, 8'h01);
         sleepSet = 1'h1;
         cyc(1);
         sleepSet = 1'h0;
      end
      $display("t_sleep done");
   endtask

   task automatic final_report();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Reset for 8 cycles, then scenarios in turn
   initial begin
      cyc(8);
      nrst = 1'h1;
      cyc(4);
      chk({5'h00, modeOut}, 8'h01);
      t_ratio();
      t_idle();
      t_sleep();
      final_report();
   end
endmodule
